// *** testbench/tas_radio.sv ***
// Purpose: behavioural radio reporting tags to the sequencer
// Assumes: bench asks for one detection at a time
// Notes: id bus is not held between detections
`timescale 1ns/1ps
module tas_radio
(
  input wire logic clk_in,
  input wire logic fire_in,
  input wire logic [15:0] id_in,
  output logic det_out,
  output logic [15:0] id_out
);
  initial det_out = 1'b0;
  initial id_out = 16'h0;
  // idle id inverts itself each cycle, so the stale value shows on every other idle cycle
  always @(posedge clk_in)
  begin
    det_out <= fire_in;
    id_out <= fire_in ? id_in : ~id_out;
  end
endmodule : tas_radio

// *** testbench/tas_seq_monitor.sv ***
// Purpose: port checks for the tag access sequencer
// Assumes: one clock, sync reset, periods of 1 or more
// Notes: helpers shadow mode, timer and antenna walk
`timescale 1ns/1ps
`include "tas_map.svh"
module tas_seq_monitor
  import tas_pkg::*;
#(
  parameter int ID_W = `TAS_ID_W,
  parameter int DEPTH = `TAS_DEPTH,
  parameter int DWELL = `TAS_DWELL,
  localparam int CW = $clog2(DEPTH) + 1
)
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic cmd_valid_in,
  input wire logic [1:0] cmd_mode_in,
  input wire logic cmd_per_en_in,
  input wire logic [`TAS_PER_W-1:0] cmd_period_in,
  input wire logic term_in,
  input wire logic [`TAS_LIST_W-1:0] ant_list_in,
  input wire logic [`TAS_LEN_W-1:0] ant_len_in,
  input wire logic tag_det_in,
  input wire logic [ID_W-1:0] tag_id_in,
  input wire logic busy_out,
  input wire logic search_out,
  input wire logic [`TAS_ENT_W-1:0] ant_port_out,
  input wire logic resp_valid_out,
  input wire logic resp_first_out,
  input wire logic resp_last_out,
  input wire logic resp_empty_out,
  input wire logic [CW-1:0] resp_count_out,
  input wire logic [ID_W-1:0] resp_id_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  logic take, expire, rend, got_ff, term_ff, pe_ff;
  logic [1:0] md_ff;
  logic [31:0] cnt_ff, per_ff;
  logic [26:0] list_ff;
  logic [3:0] len_ff, idx_ff;
  int dw_ff;
  assign take = cmd_valid_in && ce_in && !busy_out;
  assign rend = resp_valid_out && resp_last_out;
  // single repeat ignores the period
  assign expire = search_out && ce_in && pe_ff && md_ff != 2'h1
    && cnt_ff + 33'h1 >= per_ff;
  // reset reloads like a command, so no separate clear path
  always_ff @(posedge clk_in)
  begin
    if (rst_in || take)
    begin
      md_ff <= cmd_mode_in;
      pe_ff <= cmd_per_en_in;
      per_ff <= cmd_period_in;
      list_ff <= ant_list_in;
      len_ff <= ant_len_in == 4'h0 ? 4'h1 : ant_len_in > 4'h9 ? 4'h9
        : ant_len_in;
      cnt_ff <= '0;
      got_ff <= 1'b0;
      term_ff <= 1'b0;
      idx_ff <= '0;
      dw_ff <= 0;
    end
    else if (ce_in)
    begin
      term_ff <= term_ff || (busy_out && term_in);
      // the timer restarts as the last beat leaves, so any cycle
      // outside search with ce_in high brings the shadow count back to zero
      cnt_ff <= search_out ? cnt_ff + 32'h1 : '0;
      got_ff <= search_out && (got_ff || tag_det_in);
      if (search_out)
        dw_ff <= dw_ff == DWELL - 1 ? 0 : dw_ff + 1;
      if (search_out && dw_ff == DWELL - 1)
        idx_ff <= idx_ff + 4'h1 < len_ff ? idx_ff + 4'h1
          : md_ff[0] ? 4'h0 : idx_ff;
    end
  end
  a_cmd_starts_search:
    assert property (take |=> busy_out && search_out)
    else $error("command did not start");
  a_ant_list_order:
    assert property (busy_out |-> ant_port_out == 3'(list_ff >> 3 * idx_ff))
    else $error("antenna out of order");
  a_single_tag_answer:
    assert property (search_out && ce_in && tag_det_in && !term_in
      && md_ff == 2'h0 |=> !search_out ##1 resp_valid_out && resp_last_out
      && resp_count_out == CW'(1) && resp_id_out == $past(tag_id_in, 2))
    else $error("single tag answer wrong");
  a_empty_period_answer:
    assert property (expire && !got_ff && !tag_det_in && !term_in
      |=> !search_out ##1 resp_valid_out && resp_empty_out
      && resp_first_out && resp_last_out && resp_count_out == '0)
    else $error("empty answer wrong");
  a_search_holds_on:
    assert property (search_out && !term_in && !expire
      && !(tag_det_in && !md_ff[1]) |=> search_out)
    else $error("search left early");
  a_repeat_restarts:
    assert property (rend && md_ff[0] && !term_ff && !term_in
      |-> ##[1:2] search_out)
    else $error("repeat did not restart");
  a_once_finishes:
    assert property (rend && (!md_ff[0] || term_ff) |=> !busy_out)
    else $error("sequence did not finish");
  a_term_in_search:
    assert property (search_out && ce_in && term_in && !tag_det_in
      && !expire |=> !busy_out ##1 !resp_valid_out)
    else $error("terminate ignored");
  c_tag: cover property (resp_valid_out && !resp_empty_out);
  c_empty: cover property (resp_valid_out && resp_empty_out);
  c_multi: cover property (resp_valid_out && !resp_first_out);
endmodule : tas_seq_monitor

bind tas_sequencer tas_seq_monitor #(.ID_W(ID_W), .DEPTH(DEPTH),
  .DWELL(DWELL)) u_mon (
  .clk_in(clk_in),
  .rst_in(rst_in),
  .ce_in(ce_in),
  .cmd_valid_in(cmd_valid_in),
  .cmd_mode_in(cmd_mode_in),
  .cmd_per_en_in(cmd_per_en_in),
  .cmd_period_in(cmd_period_in),
  .term_in(term_in),
  .ant_list_in(ant_list_in),
  .ant_len_in(ant_len_in),
  .tag_det_in(tag_det_in),
  .tag_id_in(tag_id_in),
  .busy_out(busy_out),
  .search_out(search_out),
  .ant_port_out(ant_port_out),
  .resp_valid_out(resp_valid_out),
  .resp_first_out(resp_first_out),
  .resp_last_out(resp_last_out),
  .resp_empty_out(resp_empty_out),
  .resp_count_out(resp_count_out),
  .resp_id_out(resp_id_out)
);

// *** testbench/tb_top.sv ***
// Purpose: self-checking bench for the tag access sequencer
// Assumes: dwell of 4, periods in clock cycles
// Notes: beats: count<<20, first bit 17, last bit 16, id
`timescale 1ns/1ps
module tb_top;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ce_in = 1'b1;
  logic cmd_valid_in = 1'b0;
  logic [1:0] cmd_mode_in = 2'h0;
  logic cmd_per_en_in = 1'b0;
  logic [31:0] cmd_period_in = 32'h0;
  logic term_in = 1'b0;
  logic [26:0] ant_list_in = 27'h0;
  logic [3:0] ant_len_in = 4'h0;
  logic tag_det_in, busy_out, search_out, resp_valid_out, resp_first_out;
  logic resp_last_out, resp_empty_out, fire = 1'b0;
  logic [15:0] tag_id_in, resp_id_out, fire_id = 16'h0;
  logic [2:0] ant_port_out;
  logic [4:0] resp_count_out;
  int fail_count = 0, tests_run = 0, cyc = 0, b;
  int q[$], ids[$];
  tas_sequencer #(.DWELL(4)) DUT (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .cmd_valid_in(cmd_valid_in),
    .cmd_mode_in(cmd_mode_in),
    .cmd_per_en_in(cmd_per_en_in),
    .cmd_period_in(cmd_period_in),
    .term_in(term_in),
    .ant_list_in(ant_list_in),
    .ant_len_in(ant_len_in),
    .tag_det_in(tag_det_in),
    .tag_id_in(tag_id_in),
    .busy_out(busy_out),
    .search_out(search_out),
    .ant_port_out(ant_port_out),
    .resp_valid_out(resp_valid_out),
    .resp_first_out(resp_first_out),
    .resp_last_out(resp_last_out),
    .resp_empty_out(resp_empty_out),
    .resp_count_out(resp_count_out),
    .resp_id_out(resp_id_out)
  );
  tas_radio u_radio (.clk_in(clk_in), .fire_in(fire), .id_in(fire_id),
    .det_out(tag_det_in), .id_out(tag_id_in));
  initial forever #5 clk_in = ~clk_in;
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    tests_run++;
    if (seen !== ex)
    begin
      fail_count++;
      $display("ERROR %s expected %0h seen %0h", nm, ex, seen);
    end
  endtask : chk
  task stop_test;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  task tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask : tick
  // returns at the edge that takes the command
  // host keeps to legal lists: ports 1..4, one to nine entries
  task cmd(input logic [1:0] m, input logic pe, input int p);
    logic [26:0] l;
    for (int i = 0; i < 9; i++)
      l[3 * i +: 3] = 3'(1 + $urandom % 4);
    tick(1);
    cmd_valid_in <= 1'b1;
    cmd_mode_in <= m;
    cmd_per_en_in <= pe;
    cmd_period_in <= p;
    ant_list_in <= l;
    ant_len_in <= 4'(1 + $urandom % 9);
    tick(1);
    cmd_valid_in <= 1'b0;
  endtask : cmd
  // third tag repeats the first; single modes expect one beat per new id
  task tags(input int n, input int gap, input bit one);
    int id;
    for (int i = 0; i < n; i++)
    begin
      id = i == 2 ? ids[0] : $urandom % 65536;
      if (one && !(id inside {ids}))
        q.push_back(32'h130000 | id);
      ids.push_back(id);
      tick(1);
      fire <= 1'b1;
      fire_id <= 16'(id);
      tick(1);
      fire <= 1'b0;
      tick(gap);
    end
    if (one)
      ids = {};
  endtask : tags
  // one multi response from the ids gathered, duplicates removed
  task automatic push_resp;
    int u[$];
    foreach (ids[i])
      if (!(ids[i] inside {u}))
        u.push_back(ids[i]);
    if (u.size() == 0)
      q.push_back(32'h30000);
    foreach (u[i])
      q.push_back(u.size() << 20 | (i == 0 ? 32'h20000 : 0)
        | (i == u.size() - 1 ? 32'h10000 : 0) | u[i]);
    ids = {};
  endtask : push_resp
  task term;
    tick(1);
    term_in <= 1'b1;
    tick(1);
    term_in <= 1'b0;
  endtask : term
  // look just after the edge so busy_out has settled
  task drain;
    #1;
    while (q.size() > 0 || busy_out !== 1'b0)
    begin
      tick(1);
      #1;
    end
  endtask : drain
  // empty answer timed exactly, with a clock-enable freeze mid search
  task empty_run(input logic [1:0] m);
    int p, f;
    p = 3 + $urandom % 20;
    f = 1 + $urandom % 4;
    cmd(m, 1'b1, p);
    q.push_back(32'h30000);
    tick(2);
    ce_in <= 1'b0;
    tick(f);
    ce_in <= 1'b1;
    // beat lands on the running edge p+1 after the take edge
    tick(p - 2);
    #1 chk("early_beat", resp_valid_out, 0);
    tick(1);
    #1 chk("timed_beat", resp_valid_out, 1);
    drain();
  endtask : empty_run
  always @(negedge clk_in)
    if (resp_valid_out === 1'b1)
    begin
      b = q.size() > 0 ? q.pop_front() : 32'hfffff;
      chk("resp_id", resp_id_out, b & 32'hffff);
      chk("resp_count", resp_count_out, b >> 20);
      chk("resp_first", resp_first_out, b >> 17 & 1);
      chk("resp_last", resp_last_out, b >> 16 & 1);
      chk("resp_empty", resp_empty_out, b >> 20 == 0);
    end
  // hang guard, well above the few hundred cycles the run needs
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      fail_count++;
      stop_test();
    end
  end
  initial
  begin
    void'($urandom(5));
    tick(2);
    rst_in <= 1'b0;
    empty_run(2'h0);
    empty_run(2'h2);
    // no period: a late tag ends it, a command while busy is ignored
    cmd(2'h0, 1'b0, 0);
    tick(5 + $urandom % 30);
    cmd(2'h3, 1'b1, 2);
    tags(1, 1, 1'b1);
    drain();
    cmd(2'h0, 1'b0, 0);
    tick(20);
    term();
    drain();
    cmd(2'h2, 1'b1, 40);
    tags(4, 2, 1'b0);
    push_resp();
    drain();
    // repeat: a full period, then an empty one, then stop
    cmd(2'h3, 1'b1, 40);
    tags(3, 2, 1'b0);
    push_resp();
    push_resp();
    while (q.size() > 0)
      tick(1);
    tick(5);
    term();
    drain();
    // period is ignored here; gaps longer than it
    cmd(2'h1, 1'b1, 6);
    tags(3, 8, 1'b1);
    tick(4);
    term();
    drain();
    chk("left_beats", q.size(), 0);
    stop_test();
  end
endmodule : tb_top

// *** verilog/tas_ant_if.sv ***
// Purpose: link between sequencer and antenna stepper
// Assumes: both ends on clk_in
// Notes: list and len are held stable while run is high
`timescale 1ns/1ps
`include "tas_map.svh"
interface tas_ant_if;
  logic start; // pulse: go back to the first list entry
  logic run; // level: searching, dwell timer counts
  logic rep; // wrap to the first entry after the last
  logic [`TAS_LIST_W-1:0] list; // entry 0 in the low bits
  logic [`TAS_LEN_W-1:0] len; // entries in use
  logic [`TAS_ENT_W-1:0] port; // antenna port now selected
  modport seq (output start, run, rep, list, len, input port);
  modport step (input start, run, rep, list, len, output port);
endinterface : tas_ant_if

// *** verilog/tas_ant_step.sv ***
// Purpose: walks the antenna list one entry at a time
// Assumes: list latched by the sequencer at command start
// Notes: a once walk parks on the last entry
`timescale 1ns/1ps
`include "tas_map.svh"
module tas_ant_step
  import tas_pkg::*;
#(
  parameter int DWELL = `TAS_DWELL
)
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  tas_ant_if.step ant
);
  logic [`TAS_LEN_W-1:0] pos_ff; // current list index
  logic [`TAS_LEN_W-1:0] nxt_pos;
  logic [31:0] dw_ff; // cycles spent on this antenna
  logic [31:0] nxt_dw;
  logic [`TAS_LEN_W-1:0] len_c; // length clamped to the legal range

  // next index: step after a full dwell, wrap only when repeating
  always_comb
  begin
    if (ant.len == '0)
      len_c = `TAS_LEN_W'(1);
    else if (ant.len > `TAS_ANT_MAX)
      len_c = `TAS_ANT_MAX;
    else
      len_c = ant.len;
    nxt_pos = pos_ff;
    nxt_dw = dw_ff;
    if (ant.start)
    begin
      nxt_pos = '0;
      nxt_dw = '0;
    end
    else if (ant.run)
    begin
      if (dw_ff == 32'(DWELL - 1))
      begin
        nxt_dw = '0;
        if (pos_ff + `TAS_LEN_W'(1) >= len_c)
          nxt_pos = ant.rep ? '0 : pos_ff;
        else
          nxt_pos = pos_ff + `TAS_LEN_W'(1);
      end
      else
        nxt_dw = dw_ff + 32'h1;
    end
  end

  // register the walk; frozen while the clock enable is low
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pos_ff <= '0;
      dw_ff <= '0;
    end
    else if (ce_in)
    begin
      pos_ff <= nxt_pos;
      dw_ff <= nxt_dw;
    end
  end

  // entries are taken strictly in list order
  assign ant.port = ant.list[pos_ff * `TAS_ENT_W +: `TAS_ENT_W];
endmodule : tas_ant_step

// *** verilog/tas_map.svh ***
// Purpose: named constants for the tag access sequencer
// Assumes: included by every design file that needs a number
// Notes: definitions only, no logic
`ifndef TAS_MAP_SVH
`define TAS_MAP_SVH
// longest antenna list a command may carry
`define TAS_ANT_MAX 4'h9
// width of one antenna list entry (port number 1..4)
`define TAS_ENT_W 3
// bits of the packed antenna list, nine entries
`define TAS_LIST_W 27
// width of the antenna list length field
`define TAS_LEN_W 4
// default clock cycles spent on one antenna before stepping on
`define TAS_DWELL 1000
// default depth of the tag result store
`define TAS_DEPTH 16
// default width of a tag identifier
`define TAS_ID_W 16
// width of the host period field, in clock cycles
`define TAS_PER_W 32
`endif

// *** verilog/tas_pkg.sv ***
// Purpose: shared types of the tag access sequencer
// Assumes: constants come from tas_map.svh
// Notes: mode codes are what the host places on cmd_mode_in
package tas_pkg;
  // access sequence chosen by the host with each command
  typedef enum logic [1:0] {
    TAS_SINGLE_ONCE = 2'b00,
    TAS_SINGLE_REP = 2'b01,
    TAS_MULTI_ONCE = 2'b10,
    TAS_MULTI_REP = 2'b11
  } tas_mode_e;
  // sequencer control states
  typedef enum logic [1:0] {
    TAS_ST_IDLE = 2'b00,
    TAS_ST_SEARCH = 2'b01,
    TAS_ST_SEND = 2'b10
  } tas_state_e;
endpackage : tas_pkg

// *** verilog/tas_sequencer.sv ***
// Purpose: runs one tag access command in one of four sequences
// Assumes: all inputs come from logic on clk_in
// Notes: results leave as one beat per tag, one beat when empty
// Operation
// - host picks one of four access sequences
// - single once: first tag ends, one response
// - single once, period: timeout gives zero count
// - single once, no period: search until tag/stop
// - single repeat: report tag, restart until stop
// - single repeat: first DEPTH unread tags reported immediately
// - multi once: collect over period, one response
// - multi once: empty period still answers no tag
// - multi repeat: answer each period, then restart
// - multi repeat: empty period answers no tag
// - antenna list holds at most nine entries
// - antennas searched one by one, list order
`timescale 1ns/1ps
`include "tas_map.svh"
module tas_sequencer
  import tas_pkg::*;
#(
  parameter int ID_W = `TAS_ID_W,
  parameter int DEPTH = `TAS_DEPTH,
  parameter int DWELL = `TAS_DWELL,
  localparam int CW = $clog2(DEPTH) + 1
)
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic cmd_valid_in,
  input wire logic [1:0] cmd_mode_in,
  input wire logic cmd_per_en_in,
  input wire logic [`TAS_PER_W-1:0] cmd_period_in,
  input wire logic term_in,
  input wire logic [`TAS_LIST_W-1:0] ant_list_in,
  input wire logic [`TAS_LEN_W-1:0] ant_len_in,
  input wire logic tag_det_in,
  input wire logic [ID_W-1:0] tag_id_in,
  output logic busy_out,
  output logic search_out,
  output logic [`TAS_ENT_W-1:0] ant_port_out,
  output logic resp_valid_out,
  output logic resp_first_out,
  output logic resp_last_out,
  output logic resp_empty_out,
  output logic [CW-1:0] resp_count_out,
  output logic [ID_W-1:0] resp_id_out
);
  tas_ant_if ant (); // link to the antenna stepper

  // control state
  tas_state_e st_ff, nxt_st;
  tas_mode_e mode_ff, nxt_mode;
  logic per_en_ff, nxt_per_en; // a period was given
  logic [`TAS_PER_W-1:0] per_ff, nxt_per;
  logic [`TAS_PER_W-1:0] tmr_ff, nxt_tmr; // cycles into the period
  logic term_ff, nxt_term; // termination seen while busy
  logic [`TAS_LIST_W-1:0] list_ff, nxt_list;
  logic [`TAS_LEN_W-1:0] len_ff, nxt_len;
  logic [CW-1:0] cnt_ff, nxt_cnt; // results held in the store
  logic [CW-1:0] idx_ff, nxt_idx; // beat being sent
  logic [CW-1:0] lo_ff, nxt_lo; // first index of this response
  logic [CW-1:0] hi_ff, nxt_hi; // last index of this response
  logic emp_ff, nxt_emp; // response carries no tag
  // registered response beat
  logic rv_ff, nxt_rv;
  logic rf_ff, nxt_rf;
  logic rl_ff, nxt_rl;
  logic re_ff, nxt_re;
  logic [CW-1:0] rc_ff, nxt_rc;
  logic [ID_W-1:0] rid_ff, nxt_rid;
  // result store
  logic [ID_W-1:0] mem_ff [DEPTH];
  logic we; // write tag_id_in at cnt_ff
  logic expire; // period ends this cycle
  logic fresh; // detected tag not yet in the store

  // true when id already sits in the first cnt_ff store slots
  function automatic logic seen_f(input logic [ID_W-1:0] id);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < DEPTH; i++)
      if (i < int'(cnt_ff) && mem_ff[i] == id)
        hit = 1'b1;
    return hit;
  endfunction : seen_f

  // period expiry; only meaningful when a period was given
  assign expire = per_en_ff && (tmr_ff + `TAS_PER_W'(1) >= per_ff);
  // duplicates are dropped so the store only fills with new tags
  assign fresh = tag_det_in && !seen_f(tag_id_in)
    && (int'(cnt_ff) < DEPTH);

  // sequencer next state
  always_comb
  begin
    nxt_st = st_ff;
    nxt_mode = mode_ff;
    nxt_per_en = per_en_ff;
    nxt_per = per_ff;
    nxt_tmr = tmr_ff;
    nxt_term = term_ff || (term_in && st_ff != TAS_ST_IDLE);
    nxt_list = list_ff;
    nxt_len = len_ff;
    nxt_cnt = cnt_ff;
    nxt_idx = idx_ff;
    nxt_lo = lo_ff;
    nxt_hi = hi_ff;
    nxt_emp = emp_ff;
    nxt_rv = 1'b0;
    nxt_rf = 1'b0;
    nxt_rl = 1'b0;
    nxt_re = re_ff;
    nxt_rc = rc_ff;
    nxt_rid = rid_ff;
    we = 1'b0;
    ant.start = 1'b0;
    case (st_ff)
      TAS_ST_IDLE:
      begin
        // a new command latches mode, period and antenna list
        if (cmd_valid_in)
        begin
          nxt_mode = tas_mode_e'(cmd_mode_in);
          nxt_per_en = cmd_per_en_in;
          nxt_per = cmd_period_in;
          nxt_list = ant_list_in;
          nxt_len = ant_len_in;
          nxt_tmr = '0;
          nxt_cnt = '0;
          nxt_term = 1'b0;
          ant.start = 1'b1;
          nxt_st = TAS_ST_SEARCH;
        end
      end
      TAS_ST_SEARCH:
      begin
        nxt_tmr = tmr_ff + `TAS_PER_W'(1);
        if (nxt_term)
          nxt_st = TAS_ST_IDLE;
        else
        begin
          if (fresh)
          begin
            we = 1'b1;
            nxt_cnt = cnt_ff + CW'(1);
            // single modes answer at once with the one new tag
            if (mode_ff == TAS_SINGLE_ONCE || mode_ff == TAS_SINGLE_REP)
            begin
              nxt_lo = cnt_ff;
              nxt_hi = cnt_ff;
              nxt_idx = cnt_ff;
              nxt_emp = 1'b0;
              nxt_st = TAS_ST_SEND;
            end
          end
          // period end: single once only if no tag won this cycle
          if (expire && (mode_ff == TAS_MULTI_ONCE
              || mode_ff == TAS_MULTI_REP
              || (mode_ff == TAS_SINGLE_ONCE && !fresh)))
          begin
            nxt_lo = '0;
            nxt_idx = '0;
            nxt_hi = nxt_cnt - CW'(1);
            nxt_emp = (nxt_cnt == '0);
            nxt_st = TAS_ST_SEND;
          end
        end
      end
      TAS_ST_SEND:
      begin
        // one beat per stored result, or one empty beat
        nxt_rv = 1'b1;
        nxt_rid = emp_ff ? '0 : mem_ff[idx_ff[CW-2:0]];
        nxt_rc = emp_ff ? '0 : hi_ff - lo_ff + CW'(1);
        nxt_re = emp_ff;
        nxt_rf = (idx_ff == lo_ff);
        nxt_rl = emp_ff || (idx_ff == hi_ff);
        nxt_idx = idx_ff + CW'(1);
        if (nxt_rl)
        begin
          nxt_tmr = '0;
          if (nxt_term || mode_ff == TAS_SINGLE_ONCE
              || mode_ff == TAS_MULTI_ONCE)
            nxt_st = TAS_ST_IDLE;
          else if (mode_ff == TAS_MULTI_REP)
          begin
            nxt_cnt = '0;
            nxt_st = TAS_ST_SEARCH;
          end
          else
            nxt_st = TAS_ST_SEARCH;
        end
      end
      default:
        nxt_st = TAS_ST_IDLE;
    endcase
  end

  // sequencer registers; everything holds while ce_in is low
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      st_ff <= TAS_ST_IDLE;
      mode_ff <= TAS_SINGLE_ONCE;
      per_en_ff <= 1'b0;
      per_ff <= '0;
      tmr_ff <= '0;
      term_ff <= 1'b0;
      list_ff <= '0;
      len_ff <= '0;
      cnt_ff <= '0;
      idx_ff <= '0;
      lo_ff <= '0;
      hi_ff <= '0;
      emp_ff <= 1'b0;
      rv_ff <= 1'b0;
      rf_ff <= 1'b0;
      rl_ff <= 1'b0;
      re_ff <= 1'b0;
      rc_ff <= '0;
      rid_ff <= '0;
    end
    else if (ce_in)
    begin
      st_ff <= nxt_st;
      mode_ff <= nxt_mode;
      per_en_ff <= nxt_per_en;
      per_ff <= nxt_per;
      tmr_ff <= nxt_tmr;
      term_ff <= nxt_term;
      list_ff <= nxt_list;
      len_ff <= nxt_len;
      cnt_ff <= nxt_cnt;
      idx_ff <= nxt_idx;
      lo_ff <= nxt_lo;
      hi_ff <= nxt_hi;
      emp_ff <= nxt_emp;
      rv_ff <= nxt_rv;
      rf_ff <= nxt_rf;
      rl_ff <= nxt_rl;
      re_ff <= nxt_re;
      rc_ff <= nxt_rc;
      rid_ff <= nxt_rid;
    end
  end

  // result store write; no reset needed, cnt_ff guards reads
  always_ff @(posedge clk_in)
  begin
    if (ce_in && we)
      mem_ff[cnt_ff[CW-2:0]] <= tag_id_in;
  end

  // antenna walk runs only while searching
  assign ant.run = (st_ff == TAS_ST_SEARCH);
  assign ant.rep = (mode_ff == TAS_SINGLE_REP || mode_ff == TAS_MULTI_REP);
  assign ant.list = list_ff;
  assign ant.len = len_ff;

  tas_ant_step #(
    .DWELL(DWELL)
  ) u_step (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .ant(ant)
  );

  // outputs
  assign busy_out = (st_ff != TAS_ST_IDLE);
  assign search_out = (st_ff == TAS_ST_SEARCH);
  assign ant_port_out = ant.port;
  assign resp_valid_out = rv_ff;
  assign resp_first_out = rf_ff;
  assign resp_last_out = rl_ff;
  assign resp_empty_out = re_ff;
  assign resp_count_out = rc_ff;
  assign resp_id_out = rid_ff;
endmodule : tas_sequencer
